// ---- rtl/ptx_pkg.sv ----
// Purpose: shared constants for the parity checking bus transceiver
// Assumes: 32-bit Avalon-MM register bus, word aligned byte addresses
// Notes:   offsets are byte addresses; fields sit in the low bits
package ptx_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int BUS_W  = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h10;

   ////////////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int CTRL_W            = 6;
   localparam int CTRL_DIR          = 0; // 0: a to b, 1: b to a
   localparam int CTRL_OUT_EN_N     = 1; // bus output enable, active low
   localparam int CTRL_CLEAR_N      = 2; // fault clear, active low level
   localparam int CTRL_FAULT_DRV_N  = 3; // fault_drive_enable_n
   localparam int CTRL_REGISTERED   = 4; // 0: latched variant, 1: registered variant
   localparam int CTRL_THREE_STATE  = 5; // 0: open-drain fault pin, 1: three-state pin
   // outputs off, clear released, fault pin off, latched open-drain variant
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h0E;

   ////////////////////////////////////////////////////////////////////////////////
   // status register fields
   localparam int STAT_FAULT_STATE = 0;  // held fault level, high means good parity
   localparam int STAT_CHECK_OK    = 1;  // live checker result
   localparam int STAT_B_PAR_OK    = 2;  // even parity seen on side b data
   localparam int STAT_A_DATA_LSB  = 8;  // side a data bits
   localparam int STAT_A_PARITY    = 16; // side a parity bit

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt events
   localparam int IRQ_W          = 2;
   localparam int IRQ_FAULT_HELD = 0; // held fault level fell
   localparam int IRQ_ODD_SEEN   = 1; // checker result fell
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // bus answer states
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_ANSWER
   } ptx_bus_state_t;

endpackage : ptx_pkg

// ---- rtl/ptx_transceiver.sv ----
// Purpose: nine-bit bidirectional transceiver with an even parity checker on side a
// Assumes: one clock CORE_CLK at 10 MHz; all pin inputs synchronous to it
// Notes:   data and enables are registered, so each is one clock behind; the fault pin lags side a input by three clocks
//
// Overview of operation
// R01: direction low passes a to b, high passes b to a, never inverted.
// R02: output enable is active low; when high both sides float.
// R03: nine bits pass per transfer; parity checks only the eight data bits.
// R04: checker watches side a always, whatever direction or output enable.
// R05: odd count of high checked bits makes the checker result low.
// R06: even count of high checked bits makes the checker result high.
// R07: latched variant: while hold control is high, fault follows the checker.
// R08: latched variant: hold control low keeps the result present at that moment.
// R09: latched variant: a held fault stays until hold returns high or clear.
// R10: registered variant: each capture clock rising edge stores the checker result.
// R11: registered variant: a captured fault stays low until clear drives low; here a later capture of even parity also sets it high.
// R12: three-state variant: fault pin driven while its enable is low.
// R13: three-state variant: fault pin floats while its enable is high.
// R14: clear low forces fault high, overriding latch and register updates.

`timescale 1ns/1ps
`default_nettype none

module ptx_transceiver
   import ptx_pkg::*;
(
   input  wire logic               CORE_CLK,
   input  wire logic               ARST_N,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]  AVS_ADDRESS,
   input  wire logic               AVS_READ,
   input  wire logic               AVS_WRITE,
   input  wire logic [BUS_W-1:0]   AVS_WRITEDATA,
   input  wire logic [3:0]         AVS_BYTEENABLE,
   output logic [BUS_W-1:0]        AVS_READDATA,
   output logic                    AVS_WAITREQUEST,
   output logic                    IRQ,
   // side a pins
   input  wire logic [DATA_W-1:0]  SIDE_A_DATA_IN,
   output logic [DATA_W-1:0]       SIDE_A_DATA_OUT,
   output logic                    SIDE_A_DATA_OE,
   input  wire logic               SIDE_A_PARITY_BIT_IN,
   output logic                    SIDE_A_PARITY_BIT_OUT,
   output logic                    SIDE_A_PARITY_BIT_OE,
   // side b pins
   input  wire logic [DATA_W-1:0]  SIDE_B_DATA_IN,
   output logic [DATA_W-1:0]       SIDE_B_DATA_OUT,
   output logic                    SIDE_B_DATA_OE,
   input  wire logic               SIDE_B_PARITY_BIT_IN,
   output logic                    SIDE_B_PARITY_BIT_OUT,
   output logic                    SIDE_B_PARITY_BIT_OE,
   // fault hold and capture timing from the bus agents
   input  wire logic               FAULT_HOLD_TRANSPARENT,
   input  wire logic               FAULT_CAPTURE_CLOCK,
   // fault pin
   output logic                    FAULT_OUT,
   output logic                    FAULT_OE
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // even parity test: high when an even number of bits are high
   function automatic logic even_parity(input logic [DATA_W-1:0] bits);
      even_parity = ~(^bits);
   endfunction

   // merge a write into a narrow register under byte lane 0
   function automatic logic [IRQ_W-1:0] lane0_irq(input logic [IRQ_W-1:0] old,
                                                   input logic [BUS_W-1:0] wd,
                                                   input logic [3:0]       be);
      lane0_irq = be[0] ? wd[IRQ_W-1:0] : old;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   ptx_bus_state_t              bus_state;
   logic [CTRL_W-1:0]           ctrl;
   logic [IRQ_W-1:0]            irq_status;
   logic [IRQ_W-1:0]            irq_enable;
   logic                        check_ok;
   logic                        check_ok_prev;
   logic                        fault_state;
   logic                        fault_state_prev;
   logic                        capture_clock_prev;
   logic                        b_par_ok;
   logic                        wr_take;
   logic                        capture_edge;
   logic [IRQ_W-1:0]            next_events;
   logic [IRQ_W-1:0]            clear_bits;
   logic [BUS_W-1:0]            next_readdata;

   ////////////////////////////////////////////////////////////////////////////////
   // avalon-mm answer: one idle cycle of waitrequest, then waitrequest low for one
   // cycle with read data standing; the request is taken at that edge only

   // bus state and waitrequest; waitrequest idles high so no access completes early
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         bus_state       <= ST_IDLE;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         case (bus_state)
            ST_IDLE: begin
               if (AVS_READ || AVS_WRITE) begin
                  bus_state       <= ST_ANSWER;
                  AVS_WAITREQUEST <= 1'b0;
               end
            end
            ST_ANSWER: begin
               bus_state       <= ST_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
            default: begin
               bus_state       <= ST_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // a write takes effect at the edge where the master sees waitrequest low
   assign wr_take = AVS_WRITE && (bus_state == ST_ANSWER);

   // read mux; unmapped and write-only offsets read as zero
   always_comb begin
      next_readdata = '0;
      case (AVS_ADDRESS)
         OFS_CTRL:       next_readdata[CTRL_W-1:0] = ctrl;
         OFS_STATUS: begin
            next_readdata[STAT_FAULT_STATE]                       = fault_state;
            next_readdata[STAT_CHECK_OK]                          = check_ok;
            next_readdata[STAT_B_PAR_OK]                          = b_par_ok;
            next_readdata[STAT_A_DATA_LSB +: DATA_W]              = SIDE_A_DATA_IN;
            next_readdata[STAT_A_PARITY]                          = SIDE_A_PARITY_BIT_IN;
         end
         OFS_IRQ_STATUS: next_readdata[IRQ_W-1:0] = irq_status;
         OFS_IRQ_ENABLE: next_readdata[IRQ_W-1:0] = irq_enable;
         default:        next_readdata = '0;
      endcase
   end

   // read data is loaded as waitrequest falls and stands for that one answer cycle
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AVS_READDATA <= '0;
      end else if (bus_state == ST_IDLE && AVS_READ) begin
         AVS_READDATA <= next_readdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers

   // control register, only byte lane 0 carries fields
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl <= CTRL_RESET;
      end else if (wr_take && AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0]) begin
         ctrl <= AVS_WRITEDATA[CTRL_W-1:0];
      end
   end

   // interrupt enable register
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_enable <= IRQ_RESET;
      end else if (wr_take && AVS_ADDRESS == OFS_IRQ_ENABLE) begin
         irq_enable <= lane0_irq(irq_enable, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // parity checker

   // sampled every cycle from the side a pins, never gated by direction or enable
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         check_ok      <= 1'b1;
         check_ok_prev <= 1'b1;
         b_par_ok      <= 1'b1;
      end else begin
         check_ok      <= even_parity(SIDE_A_DATA_IN); // R03 R04 R05 R06
         check_ok_prev <= check_ok;
         b_par_ok      <= even_parity(SIDE_B_DATA_IN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fault hold: latch or register, chosen by the variant bit

   // capture clock comes in as a plain synchronous input, so a rise is seen by
   // comparing with last cycle; pulses shorter than one clock are missed
   assign capture_edge = FAULT_CAPTURE_CLOCK && !capture_clock_prev;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         capture_clock_prev <= 1'b0;
      end else begin
         capture_clock_prev <= FAULT_CAPTURE_CLOCK;
      end
   end

   // clear is a level and wins over every update while low
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         fault_state <= 1'b1;
      end else if (!ctrl[CTRL_CLEAR_N]) begin
         fault_state <= 1'b1; // R14 R09 R11
      end else if (ctrl[CTRL_REGISTERED]) begin
         if (capture_edge) begin
            fault_state <= check_ok; // R10
         end
         // otherwise the captured level, good or faulty, is kept R11
      end else if (FAULT_HOLD_TRANSPARENT) begin
         fault_state <= check_ok; // R07 R09
      end
      // latched variant with hold low keeps its value R08
   end

   // fault pin: three-state variant obeys its enable, open-drain only pulls low
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         FAULT_OUT        <= 1'b1;
         FAULT_OE         <= 1'b0;
         fault_state_prev <= 1'b1;
      end else begin
         FAULT_OUT        <= fault_state;
         fault_state_prev <= fault_state;
         if (ctrl[CTRL_THREE_STATE]) begin
            FAULT_OE <= !ctrl[CTRL_FAULT_DRV_N]; // R12 R13
         end else begin
            FAULT_OE <= !fault_state;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data path

   // both directions register the opposite pins; only the selected side is enabled
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SIDE_A_DATA_OUT       <= '0;
         SIDE_A_PARITY_BIT_OUT <= 1'b0;
         SIDE_B_DATA_OUT       <= '0;
         SIDE_B_PARITY_BIT_OUT <= 1'b0;
      end else begin
         SIDE_B_DATA_OUT       <= SIDE_A_DATA_IN;       // R01 R03
         SIDE_B_PARITY_BIT_OUT <= SIDE_A_PARITY_BIT_IN; // R03
         SIDE_A_DATA_OUT       <= SIDE_B_DATA_IN;       // R01 R03
         SIDE_A_PARITY_BIT_OUT <= SIDE_B_PARITY_BIT_IN; // R03
      end
   end

   // enables: never both sides at once, so the two buses cannot fight
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SIDE_A_DATA_OE       <= 1'b0;
         SIDE_A_PARITY_BIT_OE <= 1'b0;
         SIDE_B_DATA_OE       <= 1'b0;
         SIDE_B_PARITY_BIT_OE <= 1'b0;
      end else begin
         SIDE_B_DATA_OE       <= !ctrl[CTRL_OUT_EN_N] && !ctrl[CTRL_DIR]; // R01 R02
         SIDE_B_PARITY_BIT_OE <= !ctrl[CTRL_OUT_EN_N] && !ctrl[CTRL_DIR]; // R02
         SIDE_A_DATA_OE       <= !ctrl[CTRL_OUT_EN_N] && ctrl[CTRL_DIR];  // R01 R02
         SIDE_A_PARITY_BIT_OE <= !ctrl[CTRL_OUT_EN_N] && ctrl[CTRL_DIR];  // R02
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts

   // events are falls of the held fault and of the live checker result
   always_comb begin
      next_events                 = '0;
      next_events[IRQ_FAULT_HELD] = fault_state_prev && !fault_state;
      next_events[IRQ_ODD_SEEN]   = check_ok_prev && !check_ok;
      clear_bits                  = '0;
      if (wr_take && AVS_ADDRESS == OFS_IRQ_CLEAR) begin
         clear_bits = lane0_irq('0, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
   end

   // sticky status; a new event beats a clear written in the same cycle
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_status <= IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~clear_bits) | next_events;
      end
   end

   // level interrupt, registered from the next status value so it changes in the same cycle as status
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(((irq_status & ~clear_bits) | next_events) & irq_enable);
      end
   end

endmodule : ptx_transceiver

`default_nettype wire

// ---- verification/ptx_bus_agent.sv ----
// Purpose: far end agent on one side bus, resolves the wire level
// Assumes: where agent and design drive the same bits together, the agent level wins
// Notes:   a released wire toggles every cycle, never holds a stale value
`timescale 1ns/1ps
`default_nettype none

module ptx_bus_agent
   import ptx_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            agent_en,
   input  wire logic [DATA_W:0] agent_val,
   input  wire logic [DATA_W:0] dut_val,
   input  wire logic            dut_oe,
   input  wire logic            dut_par_oe,
   output logic      [DATA_W:0] line
);
   logic [DATA_W:0] last = '0;
   logic [DATA_W:0] drv;

   ////////////////////////////////////////////////////////////////////////////////
   // wire level: agent, else design where enabled, else inverse of last level
   assign drv = {dut_par_oe, {DATA_W{dut_oe}}};
   assign line = agent_en ? agent_val : ((dut_val & drv) | (~last & ~drv));
   always_ff @(posedge clk) last <= line;
endmodule // ptx_bus_agent

`default_nettype wire

// ---- verification/ptx_transceiver_sva.sv ----
// Purpose: port level checks of the transceiver
// Assumes: one clock domain, reset asynchronous active low
// Notes:   fault path latency is three edges from side a input
`timescale 1ns/1ps
`default_nettype none

module ptx_transceiver_sva
   import ptx_pkg::*;
(
   input wire logic              CORE_CLK,
   input wire logic              ARST_N,
   input wire logic              AVS_READ,
   input wire logic              AVS_WRITE,
   input wire logic              AVS_WAITREQUEST,
   input wire logic [DATA_W-1:0] SIDE_A_DATA_IN,
   input wire logic [DATA_W-1:0] SIDE_A_DATA_OUT,
   input wire logic              SIDE_A_DATA_OE,
   input wire logic              SIDE_A_PARITY_BIT_OE,
   input wire logic [DATA_W-1:0] SIDE_B_DATA_IN,
   input wire logic [DATA_W-1:0] SIDE_B_DATA_OUT,
   input wire logic              SIDE_B_DATA_OE,
   input wire logic              SIDE_B_PARITY_BIT_OE,
   input wire logic              FAULT_HOLD_TRANSPARENT,
   input wire logic              FAULT_CAPTURE_CLOCK,
   input wire logic              FAULT_OUT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   logic [1:0] age;

   ////////////////////////////////////////////////////////////////////////////////
   // edges since reset; $past would still see reset values before age 3
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end

   sequence s_req_start;
      $rose(AVS_READ || AVS_WRITE);
   endsequence
   sequence s_answer;
      AVS_WAITREQUEST ##[1:2] !AVS_WAITREQUEST;
   endsequence
   sequence s_gate_open;
      $past(FAULT_HOLD_TRANSPARENT, 2) ||
      ($past(FAULT_CAPTURE_CLOCK, 2) && !$past(FAULT_CAPTURE_CLOCK, 3));
   endsequence

   a_copy_to_b: assert property (age == 2'h3 |-> SIDE_B_DATA_OUT == $past(SIDE_A_DATA_IN))
      else $error("side b output is not the side a input");
   a_copy_to_a: assert property (age == 2'h3 |-> SIDE_A_DATA_OUT == $past(SIDE_B_DATA_IN))
      else $error("side a output is not the side b input");
   a_oe_exclusive: assert property (!(SIDE_A_DATA_OE && SIDE_B_DATA_OE))
      else $error("both sides driven");
   a_parity_oe_pair: assert property (SIDE_A_PARITY_BIT_OE == SIDE_A_DATA_OE &&
      SIDE_B_PARITY_BIT_OE == SIDE_B_DATA_OE) else $error("parity bit enable split");
   a_fall_odd: assert property (age == 2'h3 && $fell(FAULT_OUT) |-> $past(^SIDE_A_DATA_IN, 3))
      else $error("fault fell on even parity");
   a_fall_gated: assert property (age == 2'h3 && $fell(FAULT_OUT) |-> s_gate_open)
      else $error("fault fell with latch closed and no capture");
   a_wait_answer: assert property (s_req_start |-> s_answer)
      else $error("no answer to request");
   a_wait_one: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
      else $error("answer longer than one cycle");
   a_wait_needs_req: assert property (!AVS_WAITREQUEST |-> (AVS_READ || AVS_WRITE))
      else $error("answer without request");
endmodule // ptx_transceiver_sva

`default_nettype wire

// ---- verification/ptx_transceiver_tb_top.sv ----
// Purpose: self checking bench of the transceiver
// Assumes: agents on both sides, 10 MHz clock
// Notes:   agents never drive a side the design drives, except side b for a few cycles in t_xfer before the direction write
`timescale 1ns/1ps
`default_nettype none

module ptx_transceiver_tb_top
   import ptx_pkg::*;
;
   logic        clk = 0, arst_n = 0, rd = 0, wr = 0, hold = 1, cap = 0;
   logic        a_en = 0, b_en = 0, ap_out, bp_out, a_oe, ap_oe, b_oe, bp_oe;
   logic        wreq, irq, f_out, f_oe;
   logic [7:0]  addr = 8'h00, a_out, b_out;
   logic [31:0] wdata = 32'h0, rdata;
   logic [8:0]  a_val = 9'h000, b_val = 9'h000, a_line, b_line;
   int          mismatches = 0, num_checks = 0;

   ptx_transceiver dut (.CORE_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .IRQ(irq), .SIDE_A_DATA_IN(a_line[7:0]),
      .SIDE_A_DATA_OUT(a_out), .SIDE_A_DATA_OE(a_oe), .SIDE_A_PARITY_BIT_IN(a_line[8]),
      .SIDE_A_PARITY_BIT_OUT(ap_out), .SIDE_A_PARITY_BIT_OE(ap_oe),
      .SIDE_B_DATA_IN(b_line[7:0]), .SIDE_B_DATA_OUT(b_out), .SIDE_B_DATA_OE(b_oe),
      .SIDE_B_PARITY_BIT_IN(b_line[8]), .SIDE_B_PARITY_BIT_OUT(bp_out),
      .SIDE_B_PARITY_BIT_OE(bp_oe), .FAULT_HOLD_TRANSPARENT(hold),
      .FAULT_CAPTURE_CLOCK(cap), .FAULT_OUT(f_out), .FAULT_OE(f_oe));
   ptx_bus_agent u_side_a (.clk(clk), .agent_en(a_en), .agent_val(a_val),
      .dut_val({ap_out, a_out}), .dut_oe(a_oe), .dut_par_oe(ap_oe), .line(a_line));
   ptx_bus_agent u_side_b (.clk(clk), .agent_en(b_en), .agent_val(b_val),
      .dut_val({bp_out, b_out}), .dut_oe(b_oe), .dut_par_oe(bp_oe), .line(b_line));

   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // hold the request until waitrequest is sampled low, bounded wait
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         give_verdict();
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // settle past the edge so registered outputs have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put_a(input logic [8:0] v);
      @(posedge clk);
      a_en <= 1'b1;
      b_en <= 1'b0;
      a_val <= v;
   endtask
   task automatic put_b(input logic [8:0] v);
      @(posedge clk);
      b_en <= 1'b1;
      a_en <= 1'b0;
      b_val <= v;
   endtask
   task automatic set_hold(input logic v);
      @(posedge clk);
      hold <= v;
   endtask
   task automatic pulse_cap;
      @(posedge clk);
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      tick(3);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_xfer;
      rreg(OFS_CTRL, {26'h0, CTRL_RESET});
      rreg(8'h14, 32'h0);
      wreg(OFS_CTRL, 32'h04);
      put_a(9'h1A5);
      tick(3);
      chk({b_oe, bp_oe, a_oe, bp_out, b_out}, {3'b110, 9'h1A5});
      put_b(9'h03C);
      wreg(OFS_CTRL, 32'h05);
      tick(3);
      chk({a_oe, ap_oe, b_oe, ap_out, a_out}, {3'b110, 9'h03C});
      // side a is fed back from side b here, so the checker still watches a
      rreg(OFS_STATUS, 32'h0000_3C07);
      wreg(OFS_CTRL, 32'h07);
      tick(3);
      chk({a_oe, ap_oe, b_oe, bp_oe}, 32'h0);
   endtask
   task automatic t_parity;
      logic [8:0] v [5] = '{9'h000, 9'h001, 9'h1FF, 9'h07F, 9'h103};
      foreach (v[i]) begin
         put_a(v[i]);
         tick(4);
         chk(f_out, ~^v[i][7:0]);
      end
   endtask
   task automatic t_latch;
      put_a(9'h001);
      tick(4);
      chk(f_out, 1'b0);
      // open-drain pin only drives while the fault is low
      chk(f_oe, 1'b1);
      set_hold(1'b0);
      put_a(9'h000);
      tick(4);
      chk(f_out, 1'b0);
      wreg(OFS_CTRL, 32'h03);
      tick(3);
      chk(f_out, 1'b1);
      wreg(OFS_CTRL, 32'h07);
      put_a(9'h001);
      tick(4);
      chk(f_out, 1'b1);
      set_hold(1'b1);
      tick(4);
      chk(f_out, 1'b0);
      put_a(9'h000);
      tick(4);
      chk(f_out, 1'b1);
   endtask
   task automatic t_irq;
      wreg(OFS_IRQ_CLEAR, 32'h3);
      wreg(OFS_IRQ_ENABLE, 32'h1);
      put_a(9'h001);
      tick(5);
      chk(irq, 1'b1);
      rreg(OFS_IRQ_STATUS, 32'h3);
      wreg(OFS_IRQ_ENABLE, 32'h0);
      tick(2);
      chk(irq, 1'b0);
      rreg(OFS_IRQ_CLEAR, 32'h0);
      wreg(OFS_IRQ_CLEAR, 32'h3);
      rreg(OFS_IRQ_STATUS, 32'h0);
      put_a(9'h000);
   endtask
   task automatic t_reg;
      wreg(OFS_CTRL, 32'h17);
      put_a(9'h001);
      tick(4);
      chk(f_out, 1'b1);
      pulse_cap();
      chk(f_out, 1'b0);
      put_a(9'h000);
      tick(4);
      chk(f_out, 1'b0);
      wreg(OFS_CTRL, 32'h13);
      put_a(9'h001);
      pulse_cap();
      chk(f_out, 1'b1);
   endtask
   task automatic t_three_state;
      wreg(OFS_CTRL, 32'h27);
      tick(2);
      chk(f_oe, 1'b1);
      wreg(OFS_CTRL, 32'h2F);
      tick(2);
      chk(f_oe, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog; the run needs under two hundred cycles
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_xfer();
      t_parity();
      t_latch();
      t_irq();
      t_reg();
      t_three_state();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule // ptx_transceiver_tb_top

bind ptx_transceiver ptx_transceiver_sva u_sva (.CORE_CLK, .ARST_N, .AVS_READ, .AVS_WRITE,
   .AVS_WAITREQUEST, .SIDE_A_DATA_IN, .SIDE_A_DATA_OUT, .SIDE_A_DATA_OE,
   .SIDE_A_PARITY_BIT_OE, .SIDE_B_DATA_IN, .SIDE_B_DATA_OUT, .SIDE_B_DATA_OE,
   .SIDE_B_PARITY_BIT_OE, .FAULT_HOLD_TRANSPARENT, .FAULT_CAPTURE_CLOCK, .FAULT_OUT);

`default_nettype wire
